// *** rtl/stepper_spi_pkg.sv ***
/*
 * Shared constants and types of the stepper pre-driver serial register slave:
 * register addresses, field positions, reset values and the carrier structs.
 * Assumes the importing module runs on one 100 MHz system clock.
 */
package stepper_spi_pkg;

    // ------------------------------------------------------------------
    // packet layout
    // ------------------------------------------------------------------
    localparam int          CMD_POS       = 7;      // command_bit in the first byte
    localparam int          ADDR_W        = 5;
    localparam logic [2:0]  LAST_BIT_IDX  = 3'h7;
    localparam logic [4:0]  FIRST_BYTE_CNT = 5'h07; // bits already counted at byte 1 end
    localparam logic [4:0]  PACKET_BITS   = 5'h10;  // exactly sixteen bits commit a write
    localparam logic [4:0]  COUNT_SAT     = 5'h1f;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [4:0]  ADDR_WDOG     = 5'h00;
    localparam logic [4:0]  ADDR_CURSTEP  = 5'h01;
    localparam logic [4:0]  ADDR_DIROUT   = 5'h02;
    localparam logic [4:0]  ADDR_ENSLEEP  = 5'h03;
    localparam logic [4:0]  ADDR_SR0      = 5'h04;
    localparam logic [4:0]  ADDR_SR1      = 5'h05;
    localparam int          NUM_CTRL      = 4;

    localparam logic [7:0]  CTRL_RST      = 8'h00;
    localparam logic [7:0]  UNMAPPED_VAL  = 8'h00;
    localparam logic [6:0]  STATUS_RST    = 7'h00;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int          PIN_TYPE_POS  = 6;      // pin_output_type in direction_output_ctrl
    localparam int          DRV_EN_POS    = 7;      // driver_enable in enable_sleep_ctrl
    localparam int          SLEEP_POS     = 6;      // sleep_select in enable_sleep_ctrl

    typedef enum logic {ROLE_CMD, ROLE_WDATA} byte_role_t;

    typedef struct packed {
        logic [7:0] watchdog_timeout_ctrl;
        logic [7:0] current_step_ctrl;
        logic [7:0] direction_output_ctrl;
        logic [7:0] enable_sleep_ctrl;
    } ctrl_regs_t;

    typedef struct packed {
        logic [6:0] tempWdLive;     // live temperature range / watchdog flags
        logic [6:0] xCoilEvents;    // x-coil fault and charge pump fault events
    } status_in_t;

endpackage : stepper_spi_pkg

// *** rtl/stepper_spi_register_slave.sv ***
/*
 * Serial register slave of a stepper pre-driver: mode 0 command/data packets,
 * delayed read-back, status parity, write commit on select release.
 * Assumes serial pins arrive asynchronously and are oversampled by mclk; the
 * serial clock must stay well below mclk/4. Status inputs are mclk-domain logic.
 */
// Function
// - device is a slave only and never starts a transfer
// - select_n active low; serial output released while deselected
// - output launched on falling serial clock, input sampled on rising edge
// - bytes MSB first; byte one command and address, byte two data
// - command bit zero reads, one writes; five-bit address field
// - at eighth falling edge of a read, addressed content loads the output shifter
// - bits received during read-back are taken as the next command
// - status parity bit set when seven data bits hold odd ones
// - select may stay low across reads; commands keep decoding
// - status registers refresh only while select is high
// - write commits on select rise only after exactly sixteen bits
// - write to a read-only register changes nothing
// - each byte returns content of last received address
// - old content of the written register returns during write data
// - read after write returns the old value once more
// - addresses zero to three are read-write control registers
// - address four is live read-only temperature and watchdog status
// - address five latches x-coil faults, cleared by reading
// - in sleep, reading the fault register does not clear it
`timescale 1ns/100ps

module stepper_spi_register_slave
    import stepper_spi_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic       spiClk,
    input  wire logic       select_n,
    input  wire logic       serial_in,
    input  wire status_in_t statusIn,
    output logic            serialOut,
    output logic            serialOutEn,
    output ctrl_regs_t      ctrlRegs
);

    // ------------------------------------------------------------------
    // pin synchronisers and edge detection
    // ------------------------------------------------------------------
    // [0] first stage, [1] second stage, [2] history for edges only
    logic [2:0] clkSync_q;
    logic [2:0] selSync_q;
    logic [1:0] dinSync_q;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            clkSync_q <= 3'h0;
            selSync_q <= 3'h7;
            dinSync_q <= 2'h0;
        end else begin
            clkSync_q <= {clkSync_q[1:0], spiClk};
            selSync_q <= {selSync_q[1:0], select_n};
            dinSync_q <= {dinSync_q[0], serial_in};
        end
    end

    logic selected;
    logic selFall;
    logic selRise;
    logic sclkRise;
    logic sclkFall;
    logic sdi;

    assign selected = ~selSync_q[1];
    assign selFall  = ~selSync_q[1] &  selSync_q[2];
    assign selRise  =  selSync_q[1] & ~selSync_q[2];
    assign sclkRise = selected & ~selFall &  clkSync_q[1] & ~clkSync_q[2];
    assign sclkFall = selected & ~selFall & ~clkSync_q[1] &  clkSync_q[2];
    assign sdi      = dinSync_q[1];

    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    logic [7:0] ctrlQ [NUM_CTRL];
    logic [6:0] sr0View_q;
    logic [6:0] sr1Latch_q;
    logic [6:0] sr1View_q;
    logic       sleepMode;
    logic       pushPull;

    assign sleepMode = ctrlQ[3][SLEEP_POS];
    assign pushPull  = ctrlQ[2][PIN_TYPE_POS];

    assign ctrlRegs = '{watchdog_timeout_ctrl: ctrlQ[0],
                        current_step_ctrl:     ctrlQ[1],
                        direction_output_ctrl: ctrlQ[2],
                        enable_sleep_ctrl:     ctrlQ[3]};

    function automatic logic [7:0] withParity(input logic [6:0] data);
        withParity = {^data, data};
    endfunction : withParity

    function automatic logic [7:0] readReg(
        input logic [4:0] addr,
        input logic [6:0] sr0,
        input logic [6:0] sr1,
        input logic [7:0] c0,
        input logic [7:0] c1,
        input logic [7:0] c2,
        input logic [7:0] c3
    );
        unique case (addr)
            ADDR_WDOG:    readReg = c0;
            ADDR_CURSTEP: readReg = c1;
            ADDR_DIROUT:  readReg = c2;
            ADDR_ENSLEEP: readReg = c3;
            ADDR_SR0:     readReg = withParity(sr0);
            ADDR_SR1:     readReg = withParity(sr1);
            default:      readReg = UNMAPPED_VAL;
        endcase
    endfunction : readReg

    // ------------------------------------------------------------------
    // receive side: byte assembly and command decode
    // ------------------------------------------------------------------
    logic [7:0]  rxShift_q;
    logic [2:0]  bitIdx_q;
    logic [4:0]  bitCount_q;
    byte_role_t  role_q;
    logic [4:0]  addr_q;
    logic [7:0]  wdata_q;
    logic        pktWrite_q;
    logic        loadPending_q;
    logic        readLoad_q;
    logic        rxDone;
    logic [7:0]  rxByte;

    assign rxDone = sclkRise & (bitIdx_q == LAST_BIT_IDX);
    assign rxByte = {rxShift_q[6:0], sdi};

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rxShift_q  <= 8'h00;
            bitIdx_q   <= 3'h0;
            bitCount_q <= 5'h00;
        end else if (selFall) begin
            bitIdx_q   <= 3'h0;
            bitCount_q <= 5'h00;
        end else if (sclkRise) begin
            rxShift_q <= rxByte;
            bitIdx_q  <= bitIdx_q + 3'h1;
            if (bitCount_q != COUNT_SAT) begin
                bitCount_q <= bitCount_q + 5'h01;
            end
        end
    end

    // the address survives select release: the next frame's first byte
    // still returns the register last addressed
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            role_q     <= ROLE_CMD;
            addr_q     <= 5'h00;
            wdata_q    <= 8'h00;
            pktWrite_q <= 1'b0;
            readLoad_q <= 1'b0;
        end else if (selFall) begin
            role_q     <= ROLE_CMD;
            pktWrite_q <= 1'b0;
        end else if (rxDone) begin
            unique case (role_q)
                ROLE_CMD: begin
                    addr_q     <= rxByte[ADDR_W-1:0];
                    readLoad_q <= ~rxByte[CMD_POS];
                    if (rxByte[CMD_POS]) begin
                        role_q <= ROLE_WDATA;
                    end
                    if (bitCount_q == FIRST_BYTE_CNT) begin
                        pktWrite_q <= rxByte[CMD_POS];
                    end
                end
                ROLE_WDATA: begin
                    wdata_q    <= rxByte;
                    readLoad_q <= 1'b0;
                    role_q     <= ROLE_CMD;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            loadPending_q <= 1'b0;
        end else if (selFall) begin
            loadPending_q <= 1'b0;
        end else if (rxDone) begin
            loadPending_q <= 1'b1;
        end else if (sclkFall) begin
            loadPending_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // transmit side
    // ------------------------------------------------------------------
    logic [7:0] txShift_q;
    logic [7:0] holdData_q;
    logic [7:0] loadValue;
    logic       loadNow;

    assign loadValue = readReg(addr_q, sr0View_q, sr1View_q,
                               ctrlQ[0], ctrlQ[1], ctrlQ[2], ctrlQ[3]);
    assign loadNow   = sclkFall & loadPending_q;

    // write data is still uncommitted when loaded, so the old value comes
    // back during the data byte and again in the following command byte
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            txShift_q  <= 8'h00;
            holdData_q <= 8'h00;
        end else if (selFall) begin
            txShift_q <= holdData_q;
        end else if (loadNow) begin
            txShift_q  <= loadValue;
            holdData_q <= loadValue;
        end else if (sclkFall) begin
            txShift_q <= {txShift_q[6:0], 1'b0};
        end
    end

    // open drain only pulls low; the line floats otherwise
    assign serialOut   = pushPull & txShift_q[7];
    assign serialOutEn = selected & (pushPull | ~txShift_q[7]);

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    logic commit;

    assign commit = selRise & pktWrite_q & (bitCount_q == PACKET_BITS);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            for (int i = 0; i < NUM_CTRL; i++) begin
                ctrlQ[i] <= CTRL_RST;
            end
        end else if (commit && addr_q < ADDR_SR0) begin
            ctrlQ[addr_q[1:0]] <= wdata_q;
        end
    end

    // ------------------------------------------------------------------
    // status registers
    // ------------------------------------------------------------------
    logic [6:0] sr1Clear;

    assign sr1Clear = (loadNow && readLoad_q && addr_q == ADDR_SR1 && !sleepMode)
                      ? sr1View_q : 7'h00;

    // events keep setting the latch while selected; only the readable copy
    // is frozen, so a fault during a frame is never lost
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sr1Latch_q <= STATUS_RST;
        end else begin
            sr1Latch_q <= (sr1Latch_q & ~sr1Clear) | statusIn.xCoilEvents;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sr0View_q <= STATUS_RST;
            sr1View_q <= STATUS_RST;
        end else if (!selected) begin
            sr0View_q <= statusIn.tempWdLive;
            sr1View_q <= sr1Latch_q;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    a_hiz_deselect: assert property (!selected |-> !serialOutEn)
        else $error("serial output driven while deselected");

    a_slave_only: assert property ($rose(serialOutEn) |-> $past(selected) || selected)
        else $error("serial output enabled without a select");

    a_tx_falling: assert property ($changed(txShift_q) |-> $past(sclkFall || selFall))
        else $error("output shifter moved outside a falling edge");

    a_load_value: assert property (loadNow |=> txShift_q == $past(loadValue))
        else $error("addressed content not loaded at byte end");

    a_cmd_decode: assert property (rxDone && role_q == ROLE_CMD
        |=> addr_q == 5'($past(rxByte))
            && (role_q == ROLE_WDATA) == ($past(rxByte) >= 8'h80))
        else $error("command byte decoded wrongly");

    a_write_commit: assert property (commit && addr_q == ADDR_CURSTEP
        |=> ctrlRegs.current_step_ctrl == $past(wdata_q))
        else $error("sixteen bit write not committed");

    a_bad_length: assert property (selRise && bitCount_q != PACKET_BITS
        |=> $stable(ctrlRegs))
        else $error("packet of wrong length changed a register");

    a_ro_ignore: assert property (commit && addr_q >= ADDR_SR0 |=> $stable(ctrlRegs))
        else $error("write to read-only address changed a register");

    // checked on the shifter itself, so a broken load path shows up too
    a_status_parity: assert property (loadNow
        && (addr_q == ADDR_SR0 || addr_q == ADDR_SR1)
        |=> txShift_q[7] == ^txShift_q[6:0])
        else $error("status parity bit wrong");

    a_status_frozen: assert property (selected && !selFall ##1 selected
        |-> $stable(sr0View_q) && $stable(sr1View_q))
        else $error("status view changed while selected");

    a_read_clears: assert property (loadNow && readLoad_q && addr_q == ADDR_SR1
        && !sleepMode && statusIn.xCoilEvents == 7'h00
        |=> (sr1Latch_q & $past(sr1View_q)) == 7'h00)
        else $error("shown fault bits not cleared by read");

    a_held_reload: assert property (selFall |=> txShift_q == $past(holdData_q))
        else $error("held byte not reloaded at select fall");

    a_fault_sticky: assert property (statusIn.xCoilEvents[0] |=> sr1Latch_q[0] [*2])
        else $error("fault event not latched");

    a_sleep_keep: assert property (sleepMode |-> sr1Clear == 7'h00)
        else $error("fault register cleared in sleep");

    c_write_commit: cover property (commit && addr_q < ADDR_SR0);
    c_fault_clear:  cover property (sr1Clear != 7'h00);
    c_bad_length:   cover property (selRise && pktWrite_q && bitCount_q != PACKET_BITS);
    c_two_reads:    cover property (rxDone && role_q == ROLE_CMD ##[1:300] rxDone && readLoad_q);
    c_sleep_read:   cover property (loadNow && readLoad_q && addr_q == ADDR_SR1 && sleepMode);

endmodule : stepper_spi_register_slave

// *** tb/stepper_spi_master_model.sv ***
/*
 * Behavioural serial master for the stepper register slave: mode 0 frames
 * of up to 24 bits on a free-standing 125 ns link clock.
 * Assumes the bench resolves the data-out pin, pulled up when released.
 */
`timescale 1ns/100ps

module stepper_spi_master_model #(
    parameter real HALF_NS = 62.5
) (
    output logic      spiClk,
    output logic      select_n,
    output logic      serial_in,
    input  wire logic doPin
);
    initial begin
        spiClk    = 1'b0;
        select_n  = 1'b1;
        serial_in = 1'b0;
    end

    // rx keeps the last nBits bits seen, newest in bit 0
    task automatic xfer(input logic [23:0] tx, input int nBits, output logic [23:0] rx);
        rx = 24'h0;
        select_n = 1'b0;
        for (int i = 0; i < nBits; i++) begin
            serial_in = tx[23-i];
            #(HALF_NS);
            spiClk = 1'b1;
            rx = {rx[22:0], doPin};
            #(HALF_NS);
            spiClk = 1'b0;
        end
        #(HALF_NS);
        select_n = 1'b1;
        // a released line must not keep showing the last bit
        serial_in = ~serial_in;
        #(4*HALF_NS);
    endtask : xfer
endmodule : stepper_spi_master_model

// *** tb/tb_stepper_spi_register_slave.sv ***
/*
 * Self-checking bench of the stepper serial register slave: random and
 * corner register traffic, status parity, latched faults, gated refresh.
 * Assumes the master model and a pull-up on the data-out line.
 */
`timescale 1ns/100ps

module tb_stepper_spi_register_slave
    import stepper_spi_pkg::*;
;
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        spiClk, select_n, serial_in, serialOut, serialOutEn;
    status_in_t  statusIn = '0;
    ctrl_regs_t  ctrlRegs;
    wire         doPin = serialOutEn ? serialOut : 1'b1;
    int          fail_count = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    int          idleCnt = 0;
    int          seed = 40;
    logic [7:0]  refCtrl [4] = '{default: 8'h00};
    logic [6:0]  refTemp = 7'h00;
    logic [6:0]  refLatch = 7'h00;
    logic [7:0]  held = 8'h00;
    bit          heldKnown = 1'b1;
    logic [23:0] rx;
    logic [4:0]  cycles_list [3] = '{ADDR_SR0, ADDR_SR1, 5'h1f};
    int          bad_counts [4] = '{8, 15, 17, 24};

    always #5 mclk = ~mclk;

    stepper_spi_register_slave u_dut (
        .mclk(mclk), .sys_rst(sys_rst), .spiClk(spiClk), .select_n(select_n),
        .serial_in(serial_in), .statusIn(statusIn), .serialOut(serialOut),
        .serialOutEn(serialOutEn), .ctrlRegs(ctrlRegs));

    stepper_spi_master_model u_master (
        .spiClk(spiClk), .select_n(select_n), .serial_in(serial_in), .doPin(doPin));

    // ----------------------------------------------------------------
    // checking and expectations
    // ----------------------------------------------------------------
    task automatic checkByte(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : checkByte

    task automatic checkCtrl(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : checkCtrl

    function automatic logic [7:0] regVal(input logic [4:0] a);
        case (a)
            ADDR_WDOG, ADDR_CURSTEP, ADDR_DIROUT, ADDR_ENSLEEP: return refCtrl[a[1:0]];
            ADDR_SR0: return {^refTemp, refTemp};
            ADDR_SR1: return {^refLatch, refLatch};
            default:  return UNMAPPED_VAL;
        endcase
    endfunction : regVal

    function automatic logic [7:0] legalData(input logic [1:0] a, input logic [7:0] d);
        case (a)
            2'h0:    return d & 8'hfe;
            2'h2:    return d & 8'hd7;
            2'h3:    return d & 8'hdf;
            default: return d;
        endcase
    endfunction : legalData

    task automatic wr(input logic [4:0] a, input logic [7:0] d, input int n);
        logic [7:0] old;
        old = regVal(a);
        u_master.xfer({3'h4, a, d, 8'h5a}, n, rx);
        if (n == 16) begin
            if (heldKnown) checkByte("write byte one", held, rx[15:8]);
            checkByte("write old data", old, rx[7:0]);
            if (a < 5'h04) refCtrl[a[1:0]] = d;
        end
        held = old;
        heldKnown = (n == 16);
        @(posedge mclk);
        checkCtrl("control registers", {refCtrl[0], refCtrl[1], refCtrl[2], refCtrl[3]},
                  ctrlRegs);
    endtask : wr

    task automatic rd(input logic [4:0] a, input logic [4:0] b);
        logic [7:0] ea, eb;
        logic [6:0] shown;
        ea = regVal(a);
        eb = regVal(b);
        shown = refLatch;
        u_master.xfer({3'h0, a, 3'h0, b, 8'h00}, 24, rx);
        if (heldKnown) checkByte("read byte one", held, rx[23:16]);
        checkByte("read data first", ea, rx[15:8]);
        checkByte("read data second", eb, rx[7:0]);
        if (a == ADDR_SR0 || a == ADDR_SR1) begin
            checkByte("status parity", {7'h00, ^rx[14:8]}, {7'h00, rx[15]});
        end
        // only bits already shown are cleared; later events stay latched
        if ((a == ADDR_SR1 || b == ADDR_SR1) && !refCtrl[3][SLEEP_POS]) refLatch &= ~shown;
        held = refCtrl[0];
        heldKnown = 1'b1;
    endtask : rd

    task automatic pulse(input logic [6:0] bits);
        @(posedge mclk);
        statusIn.xCoilEvents <= bits;
        @(posedge mclk);
        statusIn.xCoilEvents <= 7'h00;
        refLatch = refLatch | bits;
        repeat (4) @(posedge mclk);
    endtask : pulse

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        idleCnt <= select_n ? idleCnt + 1 : 0;
        if (idleCnt > 4) checkByte("idle output enable", 8'h00, {7'h00, serialOutEn});
        if (cycles == 60000) begin
            fail_count++;
            test_done();
        end
    end

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge mclk);
        checkCtrl("reset values", 32'h0, ctrlRegs);
        rd(ADDR_WDOG, ADDR_CURSTEP);
        for (int i = 0; i < 24; i++) begin
            logic [4:0] a;
            a = 5'($random(seed) & 3);
            wr(a, legalData(a[1:0], 8'($random(seed))), 16);
            rd(a, 5'($random(seed) & 7));
        end
        wr(ADDR_DIROUT, 8'h40, 16);
        rd(ADDR_DIROUT, ADDR_WDOG);
        foreach (cycles_list[k]) wr(cycles_list[k], 8'hff, 16);
        foreach (bad_counts[k]) wr(ADDR_CURSTEP, 8'ha5, bad_counts[k]);
        rd(ADDR_CURSTEP, 5'h1f);
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk);
            refTemp = 7'($random(seed));
            statusIn.tempWdLive <= refTemp;
            pulse(7'($random(seed)));
            rd(ADDR_SR0, ADDR_SR1);
            rd(ADDR_SR1, ADDR_WDOG);
        end
        wr(ADDR_ENSLEEP, 8'h40, 16);
        pulse(7'h15);
        rd(ADDR_SR1, ADDR_SR1);
        rd(ADDR_SR1, ADDR_WDOG);
        wr(ADDR_ENSLEEP, 8'h00, 16);
        rd(ADDR_SR1, ADDR_WDOG);
        rd(ADDR_SR1, ADDR_WDOG);
        fork
            rd(ADDR_SR1, ADDR_SR0);
            begin
                repeat (60) @(posedge mclk);
                statusIn.tempWdLive <= 7'h7f;
                refTemp = 7'h7f;
                pulse(7'h41);
            end
        join
        rd(ADDR_SR0, ADDR_SR1);
        rd(ADDR_SR1, ADDR_WDOG);
        test_done();
    end
endmodule : tb_stepper_spi_register_slave
